// ---- core/swr_rom.sv ----
`timescale 1ns/10ps
`include "swr_regs.svh"

// How it works
// - search: true bit, complement, host bit, lsb first
// - search mismatch drops out until next reset
// - skip goes straight to memory functions
// - resume enters memory only if flag set
// - flag set only by match, search, fast match
// - flag cleared when another device is addressed
// - fast skip sets speed flag, enters memory
// - reset of 480 us returns standard speed
// - fast match: 64 bits at fast speed
// - fast device failing fast match stays fast
// - short fast reset keeps fast speed
// - standard timing unless a command set fast
// - master makes every fall except presence
// - presence after delay, held for low time
// - one bit per slot, timer from fall
// - recovery time needed before next slot
// - read zero pulls low, read one releases
// - match: 64 bits, only exact device answers
// - read identity: family, serial, crc
// - reset, presence, selection, memory, data
module swr_rom #(
   parameter swr_pkg::swr_cnt_t P_RST_LONG_CYC = 16'(`SWR_CYC(`SWR_RST_LONG_US)),
   parameter swr_pkg::swr_cnt_t P_RST_FAST_CYC = 16'(`SWR_CYC(`SWR_RST_FAST_US))
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_line_in,
   output logic o_line_out,
   output logic o_line_oe_n,
   input wire logic [63:0] i_rom_id,
   input wire logic i_mem_tx_en,
   input wire logic i_mem_tx_bit,
   output logic o_mem_active,
   output logic o_mem_bit_vld,
   output logic o_mem_bit,
   output logic o_bus_reset,
   output logic o_fast_speed_flag,
   output logic o_resume_flag,
   output logic o_search_drop
);
   import swr_pkg::*;

   swr_rom_s q, d;
   logic drive;
   logic bit_vld;
   logic bit_val;
   logic rst_pls;
   logic rst_long;
   logic tx_en;
   logic tx_bit;
   logic id_bit;
   logic [7:0] cmd;

   // ****************************************
   // bit level slot timing
   // ****************************************
   swr_slot #(
      .P_RST_LONG_CYC(P_RST_LONG_CYC),
      .P_RST_FAST_CYC(P_RST_FAST_CYC)
   ) u_slot (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_line(i_line_in),
      .i_fast(q.fast),
      .i_tx_en(tx_en),
      .i_tx_bit(tx_bit),
      .o_drive(drive),
      .o_bit_vld(bit_vld),
      .o_bit_val(bit_val),
      .o_rst_pls(rst_pls),
      .o_rst_long(rst_long)
   );

   // open drain: only ever pulls low
   assign o_line_out = 1'b0;
   assign o_line_oe_n = !drive;

   // ****************************************
   // what the next read slot carries
   // ****************************************
   assign id_bit = i_rom_id[q.bitn];
   assign cmd = {bit_val, q.sh[7:1]};

   always_comb begin
      tx_en = 1'b0;
      tx_bit = 1'b1;
      unique case (q.st)
         SWR_RS_RDID: begin
            tx_en = 1'b1;
            tx_bit = id_bit;
         end
         SWR_RS_SEARCH: begin
            if (q.ph == `SWR_PH_DEV_TRUE) begin
               tx_en = 1'b1;
               tx_bit = id_bit;
            end else if (q.ph == `SWR_PH_DEV_COMP) begin
               tx_en = 1'b1;
               tx_bit = !id_bit;
            end
         end
         SWR_RS_MEM: begin
            tx_en = i_mem_tx_en;
            tx_bit = i_mem_tx_bit;
         end
         default: begin
            tx_en = 1'b0;
         end
      endcase
   end

   // ****************************************
   // selection sequencer
   // ****************************************
   always_comb begin
      d = q;
      d.mem_vld = 1'b0;
      d.bus_rst = 1'b0;
      d.drop = 1'b0;
      if (rst_pls) begin
         // every transaction restarts from reset and presence
         d.st = SWR_RS_CMD;
         d.bitn = 6'h00;
         d.ph = `SWR_PH_DEV_TRUE;
         d.bus_rst = 1'b1;
         if (rst_long) begin
            d.fast = 1'b0;
         end
      end else if (bit_vld) begin
         unique case (q.st)
            SWR_RS_WAIT: begin
               d.st = SWR_RS_WAIT;
            end
            SWR_RS_CMD: begin
               d.sh = cmd;
               d.bitn = q.bitn + 6'h01;
               if (q.bitn == `SWR_CMD_LAST) begin
                  d.bitn = 6'h00;
                  d.st = SWR_RS_WAIT;
                  unique case (cmd)
                     `SWR_CMD_READ_ID: begin
                        d.st = SWR_RS_RDID;
                     end
                     `SWR_CMD_MATCH: begin
                        d.st = SWR_RS_MATCH;
                        d.fast_match = 1'b0;
                     end
                     `SWR_CMD_FAST_MATCH: begin
                        // identity arrives at fast speed; old speed kept for a miss
                        d.st = SWR_RS_MATCH;
                        d.fast_match = 1'b1;
                        d.fast_prev = q.fast;
                        d.fast = 1'b1;
                     end
                     `SWR_CMD_SEARCH: begin
                        d.st = SWR_RS_SEARCH;
                        d.ph = `SWR_PH_DEV_TRUE;
                     end
                     `SWR_CMD_SKIP: begin
                        d.st = SWR_RS_MEM;
                     end
                     `SWR_CMD_RESUME: begin
                        d.st = q.resume ? SWR_RS_MEM : SWR_RS_WAIT;
                     end
                     `SWR_CMD_FAST_SKIP: begin
                        d.st = SWR_RS_MEM;
                        d.fast = 1'b1;
                     end
                     default: begin
                        d.st = SWR_RS_WAIT;
                     end
                  endcase
               end
            end
            SWR_RS_RDID: begin
               d.bitn = q.bitn + 6'h01;
               if (q.bitn == `SWR_ID_LAST) begin
                  d.st = SWR_RS_MEM;
               end
            end
            SWR_RS_MATCH: begin
               d.bitn = q.bitn + 6'h01;
               if (bit_val != id_bit) begin
                  // someone else is being addressed
                  d.st = SWR_RS_WAIT;
                  d.resume = 1'b0;
                  if (q.fast_match) begin
                     d.fast = q.fast_prev;
                  end
               end else if (q.bitn == `SWR_ID_LAST) begin
                  d.st = SWR_RS_MEM;
                  d.resume = 1'b1;
               end
            end
            SWR_RS_SEARCH: begin
               unique case (q.ph)
                  `SWR_PH_DEV_TRUE: begin
                     d.ph = `SWR_PH_DEV_COMP;
                  end
                  `SWR_PH_DEV_COMP: begin
                     d.ph = `SWR_PH_HOST_SEL;
                  end
                  default: begin
                     d.ph = `SWR_PH_DEV_TRUE;
                     d.bitn = q.bitn + 6'h01;
                     if (bit_val != id_bit) begin
                        d.st = SWR_RS_WAIT;
                        d.drop = 1'b1;
                        d.resume = 1'b0;
                     end else if (q.bitn == `SWR_ID_LAST) begin
                        d.st = SWR_RS_MEM;
                        d.resume = 1'b1;
                     end
                  end
               endcase
            end
            SWR_RS_MEM: begin
               d.mem_vld = 1'b1;
               d.mem_bit = bit_val;
            end
            default: begin
               d.st = SWR_RS_WAIT;
            end
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_mem_active = (q.st == SWR_RS_MEM);
   assign o_mem_bit_vld = q.mem_vld;
   assign o_mem_bit = q.mem_bit;
   assign o_bus_reset = q.bus_rst;
   assign o_fast_speed_flag = q.fast;
   assign o_resume_flag = q.resume;
   assign o_search_drop = q.drop;

endmodule

// ---- core/swr_regs.svh ----
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

// ****************************************
// selection commands
// ****************************************
`define SWR_CMD_READ_ID     8'h33
`define SWR_CMD_MATCH       8'h55
`define SWR_CMD_SEARCH      8'hf0
`define SWR_CMD_SKIP        8'hcc
`define SWR_CMD_RESUME      8'ha5
`define SWR_CMD_FAST_SKIP   8'h3c
`define SWR_CMD_FAST_MATCH  8'h69

// ****************************************
// sizes
// ****************************************
`define SWR_ID_BITS         64
`define SWR_ID_LAST         6'h3f
`define SWR_CMD_LAST        6'h07
`define SWR_PH_DEV_TRUE     2'h0
`define SWR_PH_DEV_COMP     2'h1
`define SWR_PH_HOST_SEL     2'h2

// ****************************************
// timing, in ns and us, then cycles (least times round up)
// ****************************************
`define SWR_CLK_NS          10
`define SWR_CYC(us)         ((((us) * 1000) + `SWR_CLK_NS - 1) / `SWR_CLK_NS)
`define SWR_RST_LONG_US     480
`define SWR_RST_FAST_US     48
`define SWR_SAMPLE_STD_US   30
`define SWR_SAMPLE_FAST_US  3
`define SWR_RD_LOW_STD_US   30
`define SWR_RD_LOW_FAST_US  3
`define SWR_PDH_STD_US      15
`define SWR_PDH_FAST_US     2
`define SWR_PDL_STD_US      40
`define SWR_PDL_FAST_US     8
`define SWR_REC_STD_US      5
`define SWR_REC_FAST_US     2
`define SWR_CNT_MAX         16'hffff

`endif

// ---- core/swr_pkg.sv ----
package swr_pkg;

   typedef logic [15:0] swr_cnt_t;

   typedef enum logic [2:0] {
      SWR_SL_IDLE  = 3'b000,
      SWR_SL_LOW   = 3'b001,
      SWR_SL_PDH   = 3'b010,
      SWR_SL_PDL   = 3'b011,
      SWR_SL_REC   = 3'b100
   } swr_slot_e;

   typedef enum logic [2:0] {
      SWR_RS_WAIT   = 3'b000,
      SWR_RS_CMD    = 3'b001,
      SWR_RS_RDID   = 3'b010,
      SWR_RS_MATCH  = 3'b011,
      SWR_RS_SEARCH = 3'b100,
      SWR_RS_MEM    = 3'b101
   } swr_rom_e;

   typedef struct packed {
      swr_slot_e st;
      swr_cnt_t  cnt;
      logic      drv;
      logic      bit_vld;
      logic      bit_val;
      logic      rst_pls;
      logic      rst_long;
   } swr_slot_s;

   typedef struct packed {
      swr_rom_e   st;
      logic [5:0] bitn;
      logic [1:0] ph;
      logic [7:0] sh;
      logic       fast_match;
      logic       fast_prev;
      logic       fast;
      logic       resume;
      logic       mem_vld;
      logic       mem_bit;
      logic       bus_rst;
      logic       drop;
   } swr_rom_s;

endpackage

// ---- core/swr_slot.sv ----
`timescale 1ns/10ps
`include "swr_regs.svh"

module swr_slot #(
   parameter swr_pkg::swr_cnt_t P_RST_LONG_CYC = 16'(`SWR_CYC(`SWR_RST_LONG_US)),
   parameter swr_pkg::swr_cnt_t P_RST_FAST_CYC = 16'(`SWR_CYC(`SWR_RST_FAST_US))
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_line,
   input wire logic i_fast,
   input wire logic i_tx_en,
   input wire logic i_tx_bit,
   output logic o_drive,
   output logic o_bit_vld,
   output logic o_bit_val,
   output logic o_rst_pls,
   output logic o_rst_long
);
   import swr_pkg::*;

   swr_slot_s q, d;
   swr_cnt_t t_sample, t_rdlow, t_pdh, t_pdl, t_rec, t_rst;

   // ****************************************
   // speed dependent limits
   // ****************************************
   always_comb begin
      t_sample = i_fast ? 16'(`SWR_CYC(`SWR_SAMPLE_FAST_US)) : 16'(`SWR_CYC(`SWR_SAMPLE_STD_US));
      t_rdlow = i_fast ? 16'(`SWR_CYC(`SWR_RD_LOW_FAST_US)) : 16'(`SWR_CYC(`SWR_RD_LOW_STD_US));
      t_pdh = i_fast ? 16'(`SWR_CYC(`SWR_PDH_FAST_US)) : 16'(`SWR_CYC(`SWR_PDH_STD_US));
      t_pdl = i_fast ? 16'(`SWR_CYC(`SWR_PDL_FAST_US)) : 16'(`SWR_CYC(`SWR_PDL_STD_US));
      t_rec = i_fast ? 16'(`SWR_CYC(`SWR_REC_FAST_US)) : 16'(`SWR_CYC(`SWR_REC_STD_US));
      t_rst = i_fast ? P_RST_FAST_CYC : P_RST_LONG_CYC;
   end

   // ****************************************
   // slot engine
   // ****************************************
   always_comb begin
      d = q;
      d.bit_vld = 1'b0;
      d.rst_pls = 1'b0;
      if (q.cnt != `SWR_CNT_MAX) begin
         d.cnt = q.cnt + 16'h0001;
      end
      unique case (q.st)
         SWR_SL_IDLE: begin
            d.cnt = 16'h0000;
            if (!i_line) begin
               // timer starts at the master's falling edge
               d.st = SWR_SL_LOW;
               d.drv = i_tx_en && !i_tx_bit;
            end
         end
         SWR_SL_LOW: begin
            if (q.drv && q.cnt >= t_rdlow) begin
               d.drv = 1'b0;
            end
            if (q.cnt == t_sample) begin
               d.bit_val = i_line;
            end
            // a write-one rises long before the sample point, so the slot is held up to it
            if (i_line && !q.drv && q.cnt > t_sample) begin
               d.cnt = 16'h0000;
               if (q.cnt >= t_rst) begin
                  d.st = SWR_SL_PDH;
                  d.rst_pls = 1'b1;
                  d.rst_long = q.cnt >= P_RST_LONG_CYC;
               end else begin
                  // bit handed on only once the low proved not to be a reset
                  d.bit_vld = 1'b1;
                  d.st = SWR_SL_REC;
               end
            end
         end
         SWR_SL_PDH: begin
            if (q.cnt >= t_pdh) begin
               d.st = SWR_SL_PDL;
               d.drv = 1'b1;
               d.cnt = 16'h0000;
            end
         end
         SWR_SL_PDL: begin
            if (q.cnt >= t_pdl) begin
               d.st = SWR_SL_REC;
               d.drv = 1'b0;
               d.cnt = 16'h0000;
            end
         end
         SWR_SL_REC: begin
            // an early falling edge restarts the wait; master must honour recovery
            if (!i_line) begin
               d.cnt = 16'h0000;
            end else if (q.cnt >= t_rec) begin
               d.st = SWR_SL_IDLE;
            end
         end
         default: begin
            d.st = SWR_SL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_drive = q.drv;
   assign o_bit_vld = q.bit_vld;
   assign o_bit_val = q.bit_val;
   assign o_rst_pls = q.rst_pls;
   assign o_rst_long = q.rst_long;

endmodule

// ---- sim/swr_rom_properties.sv ----
`timescale 1ns/10ps
module swr_rom_properties #(
   parameter swr_pkg::swr_cnt_t P_RST_LONG_CYC = 16'hbb80,
   parameter swr_pkg::swr_cnt_t P_RST_FAST_CYC = 16'h12c0
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_line_in,
   input wire logic o_line_out,
   input wire logic o_line_oe_n,
   input wire logic [63:0] i_rom_id,
   input wire logic i_mem_tx_en,
   input wire logic i_mem_tx_bit,
   input wire logic o_mem_active,
   input wire logic o_mem_bit_vld,
   input wire logic o_mem_bit,
   input wire logic o_bus_reset,
   input wire logic o_fast_speed_flag,
   input wire logic o_resume_flag,
   input wire logic o_search_drop
);
   import swr_pkg::*;
   // ********
   // helper counters
   // ********
   logic [15:0] since_q;
   logic [15:0] low_q;
   logic [15:0] low_len_q;
   logic [15:0] oe_low_q;
   logic [15:0] pdh;
   logic [15:0] pdl;
   logic [15:0] rdl;
   assign pdh = o_fast_speed_flag ? 16'h00c8 : 16'h05dc;
   assign pdl = o_fast_speed_flag ? 16'h0320 : 16'h0fa0;
   assign rdl = o_fast_speed_flag ? 16'h012c : 16'h0bb8;
   // since_q and low_q saturate, so a long idle never wraps into a false presence window
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         since_q <= 16'hffff;
         low_q <= 16'h0;
         low_len_q <= 16'h0;
         oe_low_q <= 16'h0;
      end else begin
         since_q <= o_bus_reset ? 16'h0 : since_q + 16'(since_q != 16'hffff);
         low_q <= i_line_in ? 16'h0 : low_q + 16'(low_q != 16'hffff);
         if (i_line_in && low_q != 16'h0) begin
            low_len_q <= low_q;
         end
         oe_low_q <= o_line_oe_n ? 16'h0 : oe_low_q + 16'h1;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_pres_hold;
      !o_line_oe_n [*8];
   endsequence
   a_line_open: assert property (o_line_out == 1'b0) else $error("data not zero");
   a_pres_quiet: assert property (since_q < pdh - 16'h4 |-> o_line_oe_n)
      else $error("presence early");
   a_pres_hold: assert property (since_q == pdh + 16'h4 |-> s_pres_hold)
      else $error("presence missing");
   a_pres_end: assert property (since_q == pdh + pdl + 16'h4 |-> o_line_oe_n)
      else $error("presence too long");
   a_read_len: assert property ($rose(o_line_oe_n) && since_q > pdh + pdl + 16'h8 |->
      $past(oe_low_q) >= rdl - 16'h8 && $past(oe_low_q) <= rdl + 16'h2) else $error("read low length");
   a_std_start: assert property ($past(i_rst) |-> !o_fast_speed_flag && !o_resume_flag)
      else $error("flags set after reset");
   a_long_clear: assert property (o_bus_reset && (low_len_q >= P_RST_LONG_CYC ||
      $past(low_q) >= P_RST_LONG_CYC) |-> ##[0:2] !o_fast_speed_flag) else $error("speed kept");
   a_short_keep: assert property (o_bus_reset && $past(o_fast_speed_flag, 2) &&
      low_len_q < P_RST_LONG_CYC && $past(low_q) < P_RST_LONG_CYC |-> o_fast_speed_flag)
      else $error("speed lost");
   a_drop_clear: assert property (o_search_drop |-> ##[0:2] !o_resume_flag)
      else $error("resume kept");
   a_resume_src: assert property ($rose(o_resume_flag) |-> ##[0:2] o_mem_active)
      else $error("resume without select");
   a_vld_mem: assert property (o_mem_bit_vld |-> o_mem_active) else $error("bit outside memory");
endmodule
bind swr_rom swr_rom_properties #(.P_RST_LONG_CYC(P_RST_LONG_CYC), .P_RST_FAST_CYC(P_RST_FAST_CYC))
   i_swr_rom_properties (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_line_in(i_line_in),
   .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n), .i_rom_id(i_rom_id), .i_mem_tx_en(i_mem_tx_en),
   .i_mem_tx_bit(i_mem_tx_bit), .o_mem_active(o_mem_active), .o_mem_bit_vld(o_mem_bit_vld),
   .o_mem_bit(o_mem_bit), .o_bus_reset(o_bus_reset), .o_fast_speed_flag(o_fast_speed_flag),
   .o_resume_flag(o_resume_flag), .o_search_drop(o_search_drop));

// ---- sim/swr_host.sv ----
`timescale 1ns/10ps
module swr_host (
   input wire logic i_clk_sys,
   input wire logic i_line,
   output logic o_pull
);
   int smp;
   int rec;
   logic dummy;
   initial begin
      o_pull = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // a one is a short low, a zero holds past the sample point
   task automatic slot(input logic wr, input logic fast, output logic rd);
      smp = fast ? 300 : 3000;
      rec = fast ? 200 : 500;
      o_pull <= 1'b1;
      wait_cyc(wr ? 3 : smp + 10);
      o_pull <= 1'b0;
      wait_cyc(wr ? smp / 2 - 3 : 1);
      rd = i_line;
      // the slave holds the slot to its sample point, then needs its recovery
      wait_cyc(wr ? smp / 2 + rec + 15 : rec + 15);
   endtask
   task automatic send(input logic [63:0] v, input int n, input logic fast);
      for (int i = 0; i < n; i++) begin
         slot(v[i], fast, dummy);
      end
   endtask
   task automatic bus_reset(input int len, input logic fast, output logic seen);
      o_pull <= 1'b1;
      wait_cyc(len);
      o_pull <= 1'b0;
      wait_cyc(fast ? 600 : 3500);
      seen = ~i_line;
      wait_cyc(fast ? 700 : 2600);
   endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`include "swr_regs.svh"
module tb_top;
   import swr_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [63:0] i_rom_id = 64'h0;
   logic i_mem_tx_en = 1'b0;
   logic i_mem_tx_bit = 1'b0;
   logic pull;
   logic line;
   logic o_line_out, o_line_oe_n, o_mem_active, o_mem_bit_vld, o_mem_bit, o_bus_reset;
   logic o_fast_speed_flag, o_resume_flag, o_search_drop;
   logic pres;
   logic rd;
   logic wb;
   logic drop_seen = 1'b0;
   int seed;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   assign line = ~pull & o_line_oe_n;
   // shortened reset thresholds: 3500 and 400 cycles
   swr_rom #(.P_RST_LONG_CYC(16'h0dac), .P_RST_FAST_CYC(16'h0190)) i_swr_rom (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_line_in(line), .o_line_out(o_line_out),
      .o_line_oe_n(o_line_oe_n), .i_rom_id(i_rom_id), .i_mem_tx_en(i_mem_tx_en), .i_mem_tx_bit(i_mem_tx_bit),
      .o_mem_active(o_mem_active), .o_mem_bit_vld(o_mem_bit_vld), .o_mem_bit(o_mem_bit),
      .o_bus_reset(o_bus_reset), .o_fast_speed_flag(o_fast_speed_flag), .o_resume_flag(o_resume_flag),
      .o_search_drop(o_search_drop));
   swr_host i_swr_host (.i_clk_sys(i_clk_sys), .i_line(line), .o_pull(pull));
   function automatic logic exp_bit(input logic [63:0] id, input int n, input logic inv);
      return id[n] ^ inv;
   endfunction
   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rst_cmd(input logic [7:0] cmd);
      i_swr_host.bus_reset(500, 1'b1, pres);
      chk(pres, 1'b1);
      i_swr_host.send({56'h0, cmd}, 8, 1'b1);
   endtask
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (o_search_drop === 1'b1) begin
         drop_seen <= 1'b1;
      end
      // the full run needs about 115k cycles, mostly the standard speed command and the identity
      if (cyc == 125000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      seed = 32'h8668e148;
      repeat (20) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      i_rom_id <= {$random(seed), $random(seed)};
      @(posedge i_clk_sys);
      i_swr_host.bus_reset(3600, 1'b0, pres);
      chk(pres, 1'b1);
      chk(o_fast_speed_flag, 1'b0);
      i_swr_host.send({56'h0, `SWR_CMD_FAST_SKIP}, 8, 1'b0);
      chk(o_fast_speed_flag, 1'b1);
      chk(o_mem_active, 1'b1);
      chk(o_resume_flag, 1'b0);
      wb = 1'($random(seed));
      i_swr_host.slot(wb, 1'b1, rd);
      chk(o_mem_bit, wb);
      i_mem_tx_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         i_mem_tx_bit <= k[0];
         i_swr_host.slot(1'b1, 1'b1, rd);
         chk(rd, k[0]);
      end
      i_mem_tx_en <= 1'b0;
      rst_cmd(`SWR_CMD_MATCH);
      chk(o_fast_speed_flag, 1'b1);
      i_swr_host.send(i_rom_id, 64, 1'b1);
      chk(o_mem_active, 1'b1);
      chk(o_resume_flag, 1'b1);
      rst_cmd(`SWR_CMD_SKIP);
      chk(o_mem_active, 1'b1);
      rst_cmd(`SWR_CMD_RESUME);
      chk(o_mem_active, 1'b1);
      rst_cmd(`SWR_CMD_SEARCH);
      for (int k = 0; k < 4; k++) begin
         i_swr_host.slot(1'b1, 1'b1, rd);
         chk(rd, exp_bit(i_rom_id, k, 1'b0));
         i_swr_host.slot(1'b1, 1'b1, rd);
         chk(rd, exp_bit(i_rom_id, k, 1'b1));
         i_swr_host.slot(exp_bit(i_rom_id, k, k == 3), 1'b1, rd);
      end
      chk(drop_seen, 1'b1);
      chk(o_resume_flag, 1'b0);
      i_swr_host.slot(1'b1, 1'b1, rd);
      chk(rd, 1'b1);
      rst_cmd(`SWR_CMD_RESUME);
      chk(o_mem_active, 1'b0);
      i_swr_host.bus_reset(3600, 1'b1, pres);
      chk(o_fast_speed_flag, 1'b0);
      close_out;
   end
endmodule
